// ---- pkg/qdp_pkg.sv ----
/*
  Constants for the queue data port: register indices, field positions,
  reset values and sizes.
  Assumes a 32-bit classic Wishbone slave with byte addressing, where each
  register index stands at byte address four times the index.
*/
package qdp_pkg;
  // Register indices; byte address is index times four
  localparam logic [5:0] IDX_RX_CMD = 6'h02;
  localparam logic [5:0] IDX_TX_PTR = 6'h04;
  localparam logic [5:0] IDX_RX_PTR = 6'h06;
  localparam logic [5:0] IDX_DATA_LOW = 6'h08;
  localparam logic [5:0] IDX_DATA_HIGH = 6'h0A;
  localparam logic [5:0] IDX_DATA_DWORD = 6'h0C;
  localparam int ADR_W = 8;
  // Pointer register fields
  localparam int PTR_W = 11;
  localparam int AUTO_BIT = 14;
  localparam logic [10:0] PTR_RESET = 11'h000;
  localparam logic AUTO_RESET = 1'b0;
  // Command register field
  localparam int RELEASE_BIT = 0;
  // Upper word of a doubleword sits two bytes above the pointer
  localparam logic [10:0] HIGH_OFFSET = 11'h002;
  // Receive queue bytes reachable by the pointer
  localparam int RXQ_BYTES = 2048;
  // Transmit path buffer
  localparam int TXQ_DEPTH = 8;
  localparam int TXQ_W = PTR_W + 32 + 4;
  typedef enum logic {REL_IDLE = 1'b0, REL_BUSY = 1'b1} qdp_rel_e;
endpackage

// ---- hw/qdp_fifo.sv ----
/*
  Small synchronous FIFO with valid and ready on both sides; flags and the
  head word are registered so every output comes from a flip-flop.
  Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ps
module qdp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW-1:0] next_rd_ptr;
  logic [AW:0] count;
  logic [AW:0] next_count;
  logic push;
  logic pop;

  assign next_count = count + (AW+1)'(push) - (AW+1)'(pop);
  assign next_rd_ptr = !pop ? rd_ptr
    : ((rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1);
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  always_ff @(posedge clk_i)
  begin
    if (push)
    begin
      mem[wr_ptr] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      rd_ptr <= next_rd_ptr;
      count <= next_count;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      in_ready_o <= 1'b1;
      out_valid_o <= 1'b0;
    end
    else
    begin
      in_ready_o <= (next_count != (AW+1)'(DEPTH));
      out_valid_o <= (next_count != '0);
    end
  end

  // A word pushed into the slot about to be the head bypasses the array,
  // whose write lands in the same edge and is not yet readable
  always_ff @(posedge clk_i)
  begin
    if (push && next_rd_ptr == wr_ptr)
    begin
      out_data_o <= in_data_i;
    end
    else
    begin
      out_data_o <= mem[next_rd_ptr];
    end
  end
endmodule

// ---- hw/qdp_port.sv ----
/*
  Host data window into the queue memories: receive pointer with
  auto-advance, transmit pointer with auto-advance, release command and
  the queue data registers, reached over a classic Wishbone slave.
  Assumes the queue manager shares clk_i, fills the receive bytes through
  the write port, answers a release with one done pulse and drains the
  transmit buffer.
*/
`timescale 1ns/1ps
// Behaviour
// - With the receive auto-advance bit set, a data register read moves the receive pointer, except in a cycle with a release reload.
// - Each advance equals the access size: one per byte, two per word, four per doubleword.
// - The receive pointer is a host read/write field in bits 10..0, reset to zero, naming a byte.
// - A finished frame release reloads the receive pointer with the next frame's location.
// - Data register reads return receive queue bytes, data register writes go to the transmit queue.
// - The low data register carries the lower word and the high one the upper word of the doubleword.
// - Transfers work at any pointer alignment, even, odd or doubleword.
// - Byte, word and doubleword accesses mix freely with no mode change.
// - Low and high words take two word locations and a doubleword takes one location.
// - The data path is a one-direction receive buffer and a one-direction transmit buffer.
// - The release command bit clears itself once the frame memory is freed.
// - A transmit pointer with its own auto-advance bit 14 moves on data writes by the same steps.
module qdp_port (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [qdp_pkg::ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic rxq_wr_i,
  input wire logic [10:0] rxq_waddr_i,
  input wire logic [7:0] rxq_wdata_i,
  output logic rel_req_o,
  input wire logic rel_done_i,
  input wire logic [10:0] rel_next_ptr_i,
  output logic txq_valid_o,
  input wire logic txq_ready_i,
  output logic [10:0] txq_addr_o,
  output logic [31:0] txq_data_o,
  output logic [3:0] txq_sel_o
);
  logic [7:0] rxq_mem [qdp_pkg::RXQ_BYTES];
  logic [10:0] rx_ptr;
  logic rx_auto;
  logic [10:0] tx_ptr;
  logic tx_auto;
  qdp_pkg::qdp_rel_e rel_state;
  logic [5:0] idx;
  logic req;
  logic hit_low;
  logic hit_high;
  logic hit_dword;
  logic is_data;
  logic go;
  logic fifo_ready;
  logic push;
  logic [3:0] lane_mask;
  logic [3:0] acc_sel;
  logic [2:0] step;
  logic [10:0] base;
  logic [31:0] rx_word;
  logic [31:0] rd_data;
  logic [qdp_pkg::TXQ_W-1:0] fifo_out;

  assign idx = wb_adr_i[7:2];
  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign hit_low = (idx == qdp_pkg::IDX_DATA_LOW);
  assign hit_high = (idx == qdp_pkg::IDX_DATA_HIGH);
  // Doubleword location lets a 32-bit host move four bytes at once
  assign hit_dword = (idx == qdp_pkg::IDX_DATA_DWORD);
  assign is_data = hit_low || hit_high || hit_dword;
  // Writes wait while the transmit buffer is full instead of losing data
  assign go = req && !(wb_we_i && is_data && !fifo_ready);
  assign push = go && wb_we_i && is_data;

  // Word registers use lanes 0 and 1 only; the dword location uses all
  assign lane_mask = hit_dword ? 4'hF : 4'h3;
  assign acc_sel = wb_sel_i & lane_mask;
  // Upper word sits two bytes above the pointer
  assign base = hit_high ? qdp_pkg::HIGH_OFFSET : 11'h000;

  always_comb
  begin
    step = 3'h0;
    for (int k = 0; k < 4; k++)
    begin
      step = step + 3'(acc_sel[k]);
    end
  end

  // Lane k reads the byte k places past the pointer plus base, wrapping at the end
  for (genvar k = 0; k < 4; k++)
  begin : g_lane
    logic [10:0] at;
    assign at = rx_ptr + base + 11'(k);
    assign rx_word[8*k+7:8*k] = acc_sel[k] ? rxq_mem[at] : 8'h00;
  end

  always_comb
  begin
    rd_data = 32'h0000_0000;
    unique case (idx)
      qdp_pkg::IDX_RX_CMD:
        rd_data[qdp_pkg::RELEASE_BIT] = (rel_state == qdp_pkg::REL_BUSY);
      qdp_pkg::IDX_TX_PTR:
      begin
        rd_data[qdp_pkg::AUTO_BIT] = tx_auto;
        rd_data[10:0] = tx_ptr;
      end
      qdp_pkg::IDX_RX_PTR:
      begin
        rd_data[qdp_pkg::AUTO_BIT] = rx_auto;
        rd_data[10:0] = rx_ptr;
      end
      qdp_pkg::IDX_DATA_LOW, qdp_pkg::IDX_DATA_HIGH,
      qdp_pkg::IDX_DATA_DWORD:
        rd_data = rx_word;
      default:
        rd_data = 32'h0000_0000;
    endcase
  end

  // Queue manager fills receive bytes; the host side only reads them
  always_ff @(posedge clk_i)
  begin
    if (rxq_wr_i)
    begin
      rxq_mem[rxq_waddr_i] <= rxq_wdata_i;
    end
  end

  // Bus answer: one wait state, ack for one cycle, unmapped reads zero
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
    else
    begin
      wb_ack_o <= go;
      if (go && !wb_we_i)
      begin
        wb_dat_o <= rd_data;
      end
    end
  end

  // Receive pointer: release reload first, then host write, then advance
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rx_ptr <= qdp_pkg::PTR_RESET;
      rx_auto <= qdp_pkg::AUTO_RESET;
    end
    else if (rel_state == qdp_pkg::REL_BUSY && rel_done_i)
    begin
      rx_ptr <= rel_next_ptr_i;
    end
    else if (go && wb_we_i && idx == qdp_pkg::IDX_RX_PTR)
    begin
      if (wb_sel_i[0])
      begin
        rx_ptr[7:0] <= wb_dat_i[7:0];
      end
      if (wb_sel_i[1])
      begin
        rx_ptr[10:8] <= wb_dat_i[10:8];
        rx_auto <= wb_dat_i[qdp_pkg::AUTO_BIT];
      end
    end
    else if (go && !wb_we_i && is_data && rx_auto)
    begin
      rx_ptr <= rx_ptr + 11'(step);
    end
    // With rx_auto clear nothing else moves the pointer
  end

  // Transmit pointer mirrors the receive one, advancing on data writes
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      tx_ptr <= qdp_pkg::PTR_RESET;
      tx_auto <= qdp_pkg::AUTO_RESET;
    end
    else if (go && wb_we_i && idx == qdp_pkg::IDX_TX_PTR)
    begin
      if (wb_sel_i[0])
      begin
        tx_ptr[7:0] <= wb_dat_i[7:0];
      end
      if (wb_sel_i[1])
      begin
        tx_ptr[10:8] <= wb_dat_i[10:8];
        tx_auto <= wb_dat_i[qdp_pkg::AUTO_BIT];
      end
    end
    else if (push && tx_auto)
    begin
      tx_ptr <= tx_ptr + 11'(step);
    end
  end

  // Release command: host sets, done from the queue manager clears.
  // A set arriving with done wins so no release is lost.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rel_state <= qdp_pkg::REL_IDLE;
    end
    else if (go && wb_we_i && idx == qdp_pkg::IDX_RX_CMD && wb_sel_i[0]
             && wb_dat_i[qdp_pkg::RELEASE_BIT])
    begin
      rel_state <= qdp_pkg::REL_BUSY;
    end
    else if (rel_done_i)
    begin
      rel_state <= qdp_pkg::REL_IDLE;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rel_req_o <= 1'b0;
    end
    else
    begin
      rel_req_o <= (rel_state == qdp_pkg::REL_BUSY) && !rel_done_i;
    end
  end

  // Transmit buffer; its full state stalls the bus ack
  qdp_fifo #(
    .WIDTH(qdp_pkg::TXQ_W),
    .DEPTH(qdp_pkg::TXQ_DEPTH)
  ) u_txq (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .in_valid_i(push),
    .in_ready_o(fifo_ready),
    .in_data_i({tx_ptr + base, wb_dat_i & {{8{acc_sel[3]}},
               {8{acc_sel[2]}}, {8{acc_sel[1]}}, {8{acc_sel[0]}}},
               acc_sel}),
    .out_valid_o(txq_valid_o),
    .out_ready_i(txq_ready_i),
    .out_data_o(fifo_out)
  );

  assign txq_addr_o = fifo_out[qdp_pkg::TXQ_W-1:36];
  assign txq_data_o = fifo_out[35:4];
  assign txq_sel_o = fifo_out[3:0];

  a_rx_auto_step: assert property (@(posedge clk_i) disable iff (rst_i)
    go && !wb_we_i && is_data && rx_auto && rel_state == qdp_pkg::REL_IDLE
    |=> rx_ptr == $past(rx_ptr) + 11'($past(step)))
    else $error("receive pointer did not advance by access size");

  a_step_size: assert property (@(posedge clk_i) disable iff (rst_i)
    go && is_data && acc_sel inside {4'h1, 4'h3, 4'hF}
    |-> step == (acc_sel == 4'h1 ? 3'h1 : (acc_sel == 4'h3 ? 3'h2 : 3'h4)))
    else $error("step does not match access size");

  a_rx_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    go && is_data && !rx_auto && !rel_done_i |=> $stable(rx_ptr))
    else $error("receive pointer moved with auto-advance clear");

  a_rx_reset: assert property (@(posedge clk_i)
    $past(rst_i) |-> rx_ptr == qdp_pkg::PTR_RESET && !rx_auto)
    else $error("receive pointer not zero after reset");

  a_release_reload: assert property (@(posedge clk_i)
    disable iff (rst_i)
    rel_state == qdp_pkg::REL_BUSY && rel_done_i
    |=> rx_ptr == $past(rel_next_ptr_i))
    else $error("pointer not reloaded on release");

  a_write_push: assert property (@(posedge clk_i) disable iff (rst_i)
    req && wb_we_i && is_data && fifo_ready |-> push ##1 wb_ack_o)
    else $error("data write not queued for transmit");

  a_full_stall: assert property (@(posedge clk_i) disable iff (rst_i)
    req && wb_we_i && is_data && !fifo_ready |=> !wb_ack_o)
    else $error("write acknowledged while buffer full");

  a_release_clear: assert property (@(posedge clk_i)
    disable iff (rst_i)
    rel_state == qdp_pkg::REL_BUSY && rel_done_i && !req
    |=> rel_state == qdp_pkg::REL_IDLE ##1 !rel_req_o)
    else $error("release bit did not clear");

  a_release_req: assert property (@(posedge clk_i) disable iff (rst_i)
    rel_state == qdp_pkg::REL_BUSY && !rel_done_i |=> rel_req_o)
    else $error("release request not raised while busy");

  a_tx_step: assert property (@(posedge clk_i) disable iff (rst_i)
    push && tx_auto |=> tx_ptr == $past(tx_ptr) + 11'($past(step)))
    else $error("transmit pointer did not advance");

  a_ack_single: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
endmodule

// ---- tb/qdp_qm_model.sv ----
/*
  Queue manager model: fills every receive byte after reset, answers a
  release after a delay and drains the transmit stream unless stalled.
  Assumes it shares clk_i and rst_i with the port; stall_i is the bench's.
*/
`timescale 1ns/1ps
module qdp_qm_model #(
  parameter logic [10:0] NEXT_PTR = 11'h123,
  parameter int REL_DLY = 12
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic stall_i,
  output logic filled_o,
  output logic rxq_wr_o,
  output logic [10:0] rxq_waddr_o,
  output logic [7:0] rxq_wdata_o,
  input wire logic rel_req_i,
  output logic rel_done_o,
  output logic [10:0] rel_next_ptr_o,
  output logic txq_ready_o
);
  logic [11:0] fill;
  int cnt;
  assign filled_o = fill[11];
  assign rxq_wr_o = !rst_i && !fill[11];
  assign rxq_waddr_o = fill[10:0];
  assign rxq_wdata_o = fill[7:0] + {fill[10:8], 5'h00};
  // Location means nothing outside done, so show a changed value there
  assign rel_next_ptr_o = rel_done_o ? NEXT_PTR : ~NEXT_PTR;
  assign txq_ready_o = !stall_i;
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      fill <= 12'h000;
    else if (!fill[11])
      fill <= fill + 12'h001;
  end
  // Slow answer keeps the command bit readable as busy for a while
  always_ff @(posedge clk_i)
  begin
    rel_done_o <= 1'b0;
    if (rst_i || !rel_req_i)
      cnt <= 0;
    else if (cnt == REL_DLY)
    begin
      rel_done_o <= 1'b1;
      cnt <= 0;
    end
    else
      cnt <= cnt + 1;
  end
endmodule

// ---- tb/tb_top.sv ----
/*
  Testbench for the queue data port: receive reads by table, transmit
  writes through a full buffer, release and reset values.
  Assumes the port and the queue manager model share one clock.
*/
`timescale 1ns/1ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin n_mismatch++; \
  $display("Error t=%0t got=%h exp=%h", $time, a, b); end end
module tb_top;
  typedef struct {logic [10:0] p; logic a; logic [7:0] adr; logic [3:0] s;
    logic [10:0] np;} qdp_row_s;
  logic clk_i, rst_i, cyc, stb, we, stall, filled, rxq_wr, rel_req, rel_done;
  logic ack, txq_valid, txq_ready;
  logic [7:0] adr, rxq_wdata;
  logic [3:0] sel, txq_sel;
  logic [31:0] dat, dat_o, txq_data, q, e, m;
  logic [10:0] rxq_waddr, rel_next, txq_addr, tp;
  logic [46:0] exp_q[$];
  logic [46:0] want;
  int n_mismatch = 0, n_compared = 0, cyc_n = 0;
  qdp_row_s rows[6] = '{
    '{11'h005, 1'b1, 8'h20, 4'h1, 11'h006},
    '{11'h006, 1'b1, 8'h28, 4'h3, 11'h008},
    '{11'h00B, 1'b1, 8'h30, 4'hF, 11'h00F},
    '{11'h7FE, 1'b1, 8'h30, 4'hF, 11'h002},
    '{11'h010, 1'b0, 8'h20, 4'h3, 11'h010},
    '{11'h021, 1'b1, 8'h20, 4'h2, 11'h022}};
  qdp_port dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
    .wb_dat_o(dat_o), .wb_ack_o(ack), .rxq_wr_i(rxq_wr),
    .rxq_waddr_i(rxq_waddr), .rxq_wdata_i(rxq_wdata), .rel_req_o(rel_req),
    .rel_done_i(rel_done), .rel_next_ptr_i(rel_next),
    .txq_valid_o(txq_valid), .txq_ready_i(txq_ready),
    .txq_addr_o(txq_addr), .txq_data_o(txq_data), .txq_sel_o(txq_sel));
  qdp_qm_model qm (.clk_i(clk_i), .rst_i(rst_i), .stall_i(stall),
    .filled_o(filled), .rxq_wr_o(rxq_wr), .rxq_waddr_o(rxq_waddr),
    .rxq_wdata_o(rxq_wdata), .rel_req_i(rel_req), .rel_done_o(rel_done),
    .rel_next_ptr_o(rel_next), .txq_ready_o(txq_ready));
  function automatic logic [7:0] fb(input logic [10:0] p);
    return p[7:0] + {p[10:8], 5'h00};
  endfunction
  task automatic report_and_stop();
    if (n_mismatch == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // Holds the request until the edge that samples ack high
  task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] s,
    input logic [31:0] d, output logic [31:0] r);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    dat <= d;
    do
      @(posedge clk_i);
    while (ack !== 1'b1);
    r = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  initial
  begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  always @(posedge clk_i)
  begin
    cyc_n++;
    if (cyc_n == 10000)
    begin
      n_mismatch++;
      report_and_stop();
    end
  end
  always @(posedge clk_i)
  begin
    if (!rst_i && txq_valid === 1'b1 && txq_ready === 1'b1)
    begin
      want = exp_q.pop_front();
      `CHK({txq_addr, txq_data, txq_sel}, want)
    end
  end
  initial
  begin
    rst_i = 1'b1;
    {cyc, stb, we, stall, adr, sel, dat} = '0;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    `CHK({rel_req, txq_valid}, 2'b00)
    while (filled !== 1'b1)
      @(posedge clk_i);
    wb(1'b0, 8'h18, 4'h3, 32'h0, q);
    `CHK(q[14:0], 15'h0000)
    wb(1'b0, 8'h3C, 4'hF, 32'h0, q);
    `CHK(q, 32'h00000000)
    // Row: set pointer and auto, read one data register, check pointer
    foreach (rows[i])
    begin
      wb(1'b1, 8'h18, 4'h3, {17'h0, rows[i].a, 3'h0, rows[i].p}, q);
      wb(1'b0, rows[i].adr, rows[i].s, 32'h0, q);
      e = '0;
      m = '0;
      for (int k = 0; k < 4; k++)
        if (rows[i].s[k])
        begin
          m[8*k +: 8] = 8'hFF;
          e[8*k +: 8] = fb(rows[i].p + (rows[i].adr == 8'h28 ? 2 : 0) + k);
        end
      `CHK(q & m, e)
      wb(1'b0, 8'h18, 4'h3, 32'h0, q);
      `CHK(q[10:0], rows[i].np)
    end
    // Transmit: odd start, mixed sizes, buffer filled while stalled
    tp = 11'h3FD;
    wb(1'b1, 8'h10, 4'h3, {17'h0, 1'b1, 3'h0, tp}, q);
    stall <= 1'b1;
    for (int i = 0; i < 8; i++)
    begin
      e = 32'hA1B2C300 + i;
      if (i % 2 == 0)
      begin
        exp_q.push_back({tp, e, 4'hF});
        wb(1'b1, 8'h30, 4'hF, e, q);
        tp = tp + 11'h004;
      end
      else
      begin
        // Odd entries alternate low and high word registers
        m[10:0] = (i % 4 == 3) ? 11'h002 : 11'h000;
        exp_q.push_back({tp + m[10:0], 16'h0000, e[15:0], 4'h3});
        wb(1'b1, (i % 4 == 3) ? 8'h28 : 8'h20, 4'h3, e, q);
        tp = tp + 11'h002;
      end
    end
    exp_q.push_back({tp, 32'h5A5AF00F, 4'hF});
    fork
      wb(1'b1, 8'h30, 4'hF, 32'h5A5AF00F, q);
      begin
        repeat (10)
        begin
          @(posedge clk_i);
          `CHK(ack, 1'b0)
        end
        stall <= 1'b0;
      end
    join
    tp = tp + 11'h004;
    repeat (20) @(posedge clk_i);
    `CHK({txq_valid, exp_q.size()}, {1'b0, 32'd0})
    wb(1'b0, 8'h10, 4'h3, 32'h0, q);
    `CHK(q[10:0], tp)
    // Release: bit reads busy, then clears and reloads the pointer
    wb(1'b1, 8'h08, 4'h1, 32'h1, q);
    wb(1'b0, 8'h08, 4'h1, 32'h0, q);
    `CHK({q[0], rel_req}, 2'b11)
    for (int i = 0; i < 40 && q[0] !== 1'b0; i++)
      wb(1'b0, 8'h08, 4'h1, 32'h0, q);
    `CHK({q[0], rel_req}, 2'b00)
    wb(1'b0, 8'h18, 4'h3, 32'h0, q);
    `CHK(q[10:0], 11'h123)
    // Mid-run reset clears a moved pointer and a set auto bit
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    `CHK({rel_req, txq_valid, ack}, 3'b000)
    wb(1'b0, 8'h18, 4'h3, 32'h0, q);
    `CHK(q[14:0], 15'h0000)
    report_and_stop();
  end
endmodule
